// >>> design/far_pkg.sv
// Package for the flow alarm relay block: types, reset values and timing constants
package far_pkg;

   // Switching condition codes
   typedef enum logic [2:0] {
      FAR_FUNC_OFF   = 3'h0,
      FAR_FUNC_MAX   = 3'h1,
      FAR_FUNC_MIN   = 3'h2,
      FAR_FUNC_DIR   = 3'h3,
      FAR_FUNC_QUANT = 3'h4,
      FAR_FUNC_ERROR = 3'h5
   } far_func_e;

   // Relay sequencing states, one-hot
   typedef enum logic [3:0] {
      FAR_ST_STOP   = 4'h1,
      FAR_ST_IDLE   = 4'h2,
      FAR_ST_ACTIVE = 4'h4,
      FAR_ST_HOLD   = 4'h8
   } far_state_e;

   localparam int FAR_VAL_W = 32;
   localparam int FAR_CNT_W = 5;

   // Alarm configuration carried as one word
   typedef struct packed {
      logic [2:0] func;
      logic latch;
      logic nc;
      logic signed [31:0] limit;
      logic [31:0] hyst;
   } far_cfg_s;

   // Measurement inputs carried together
   typedef struct packed {
      logic running;
      logic valid;
      logic signed [31:0] value;
      logic signed [31:0] total_pos;
      logic signed [31:0] total_neg;
      logic fail;
   } far_meas_s;

   // Register map of the plain register port
   localparam logic [3:0] FAR_ADDR_CTRL = 4'h0;
   localparam logic [3:0] FAR_ADDR_LIMIT = 4'h1;
   localparam logic [3:0] FAR_ADDR_HYST = 4'h2;
   localparam logic [3:0] FAR_ADDR_STAT = 4'h3;
   localparam logic [3:0] FAR_ADDR_CMD = 4'h4;

   // Control field positions
   localparam int FAR_CTRL_FUNC_LSB = 0;
   localparam int FAR_CTRL_LATCH = 3;
   localparam int FAR_CTRL_NC = 4;
   localparam int FAR_CTRL_EN = 5;
   localparam int FAR_CTRL_SHOW = 6;
   localparam int FAR_CTRL_TOTRST = 7;
   localparam int FAR_CMD_RESET = 0;

   // Values after reset
   localparam logic signed [31:0] FAR_LIMIT_RST = 32'h0000_0000;
   localparam logic [31:0] FAR_HYST_RST = 32'h0000_0000;
   localparam logic [2:0] FAR_FUNC_RST = 3'h0;

   // Timing
   localparam int FAR_CLK_HZ = 25_000_000;
   localparam int FAR_TICK_S = 1;
   localparam int FAR_TICK_CYC = FAR_CLK_HZ * FAR_TICK_S;
   localparam int FAR_ERR_FAILS = 5;

endpackage

// >>> design/far_relay.sv
// Single alarm relay controller of a flow measuring instrument
// Functional notes
// - Above/below limits use symmetric hysteresis band centred on limit.
// - Zero hysteresis width compares value directly to limit.
// - Comparison uses full-precision value, never display rounding.
// - Reset/init: condition off, non-latching, normally open, limit zero.
// - Manual reset idles relay; still-true condition re-activates after 1 s.
// - Measurement stopped: relay de-energized regardless of idle polarity.
// - Positioning start puts relay into programmed idle state.
// - Latched alarm stays idle after positioning if condition gone.
// - Above/below conditions re-evaluated at most once per second.
// - Non-latching alarm follows condition, on at least 1 s.
// - Totalizer condition fires when totalizer reaches limit.
// - Error condition needs several consecutive failed measurements.
// - Direction change, non-latching: about 1 s pulse each sign change.
// - Direction change, latching: active at first change until reset.
// - No switching during internal adaptation.
// - Condition off forces normally open polarity.
// - Disabling the output keeps its configuration for re-enable.
// - Manual totalizer reset enabled: alarm reset request ignored.
// - Normally open energizes when active; normally closed inverts.
// - Latching holds after clear; non-latching idles at clear once its at least 1 s (two ticks) of on-time has passed.
// - Above: value exceeds limit; below: value under limit.
// - No measurement running: relay kept de-energized.
`timescale 1ns/1ns
`default_nettype none

module far_relay
   import far_pkg::*;
#(
   parameter int TICK_CYC = FAR_TICK_CYC,
   parameter int ERR_FAILS = FAR_ERR_FAILS
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire far_meas_s meas_i,
   input wire logic positioning_i,
   input wire logic adapting_i,
   output logic alarm_relay_output_o,
   output logic relay_state_display_enable_o
);

   logic [7:0] ctrl_reg;
   logic signed [31:0] limit_reg;
   logic [31:0] hyst_reg;
   far_state_e state_reg;
   logic [31:0] presc_reg;
   logic tick;
   logic rst_req;
   logic cond;
   logic lvl_reg;
   logic sign_reg;
   logic dir_evt;
   logic [FAR_CNT_W-1:0] fail_cnt_reg;
   logic pos_d_reg;
   logic active;
   logic [1:0] on_cnt_reg;
   far_func_e func;
   logic latch;
   logic enabled;
   logic signed [32:0] half;
   logic signed [32:0] up_thr;
   logic signed [32:0] lo_thr;
   logic signed [32:0] val_x;
   logic dir_seen_reg;

   assign func = far_func_e'(ctrl_reg[FAR_CTRL_FUNC_LSB +: 3]);
   assign latch = ctrl_reg[FAR_CTRL_LATCH];
   assign enabled = ctrl_reg[FAR_CTRL_EN];
   assign relay_state_display_enable_o = ctrl_reg[FAR_CTRL_SHOW];

   // Register writes; function off forces NO polarity
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_reg <= {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FAR_FUNC_RST};
         limit_reg <= FAR_LIMIT_RST;
         hyst_reg <= FAR_HYST_RST;
      end else if (clk_en_i && reg_wr_i) begin
         // Whole control byte written; enable and all other fields replaced
         if (reg_addr_i == FAR_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata_i[7:0];
            if (reg_wdata_i[2:0] == FAR_FUNC_OFF) begin
               ctrl_reg[FAR_CTRL_NC] <= 1'b0;
            end
         end
         if (reg_addr_i == FAR_ADDR_LIMIT) begin
            limit_reg <= reg_wdata_i;
         end
         if (reg_addr_i == FAR_ADDR_HYST) begin
            hyst_reg <= reg_wdata_i;
         end
      end
   end

   // Manual reset ignored while totalizer manual reset owns the key
   assign rst_req = clk_en_i && reg_wr_i && reg_addr_i == FAR_ADDR_CMD
      && reg_wdata_i[FAR_CMD_RESET] && !ctrl_reg[FAR_CTRL_TOTRST];

   // Read port, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (clk_en_i) begin
         reg_rdata_o <= 32'h0000_0000;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               FAR_ADDR_CTRL: reg_rdata_o <= {24'h00_0000, ctrl_reg};
               FAR_ADDR_LIMIT: reg_rdata_o <= limit_reg;
               FAR_ADDR_HYST: reg_rdata_o <= hyst_reg;
               FAR_ADDR_STAT: reg_rdata_o <= {26'h000_0000, dir_seen_reg, lvl_reg,
                  alarm_relay_output_o, active, cond, meas_i.running};
               default: reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // One-second prescaler
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         presc_reg <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (presc_reg >= 32'(TICK_CYC - 1)) begin
            presc_reg <= 32'h0000_0000;
         end else begin
            presc_reg <= presc_reg + 32'h0000_0001;
         end
      end
   end
   assign tick = clk_en_i && (presc_reg >= 32'(TICK_CYC - 1));

   // Thresholds on the unrounded value
   assign half = 33'(signed'({1'b0, hyst_reg[31:1]}));
   assign val_x = 33'(meas_i.value);
   assign up_thr = 33'(limit_reg) + half;
   assign lo_thr = 33'(limit_reg) - half;

   // Hysteresis level, updated only on the tick
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lvl_reg <= 1'b0;
      end else if (tick && meas_i.valid && !adapting_i) begin
         if (func == FAR_FUNC_MAX) begin
            if (hyst_reg == 32'h0000_0000) begin
               lvl_reg <= val_x > 33'(limit_reg);
            end else if (val_x > up_thr) begin
               lvl_reg <= 1'b1;
            end else if (val_x < lo_thr) begin
               lvl_reg <= 1'b0;
            end
         end else if (func == FAR_FUNC_MIN) begin
            if (hyst_reg == 32'h0000_0000) begin
               lvl_reg <= val_x < 33'(limit_reg);
            end else if (val_x < lo_thr) begin
               lvl_reg <= 1'b1;
            end else if (val_x > up_thr) begin
               lvl_reg <= 1'b0;
            end
         end else begin
            lvl_reg <= 1'b0;
         end
      end
   end

   // Consecutive failure counter
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fail_cnt_reg <= '0;
      end else if (clk_en_i && meas_i.valid) begin
         if (!meas_i.fail) begin
            fail_cnt_reg <= '0;
         end else if (fail_cnt_reg < FAR_CNT_W'(ERR_FAILS)) begin
            fail_cnt_reg <= fail_cnt_reg + FAR_CNT_W'(1);
         end
      end
   end

   // Flow sign tracking for direction change
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sign_reg <= 1'b0;
         dir_seen_reg <= 1'b0;
      end else if (clk_en_i && meas_i.valid) begin
         sign_reg <= meas_i.value[31];
         dir_seen_reg <= meas_i.running;
      end
   end
   assign dir_evt = meas_i.valid && dir_seen_reg && (meas_i.value[31] != sign_reg)
      && func == FAR_FUNC_DIR;

   // Combined switching condition
   always_comb begin
      cond = 1'b0;
      unique case (func)
         FAR_FUNC_MAX, FAR_FUNC_MIN: cond = lvl_reg;
         FAR_FUNC_QUANT: cond = limit_reg[31] ? (meas_i.total_neg <= limit_reg)
            : (meas_i.total_pos >= limit_reg);
         FAR_FUNC_ERROR: cond = fail_cnt_reg >= FAR_CNT_W'(ERR_FAILS);
         FAR_FUNC_DIR: cond = dir_evt;
         default: cond = 1'b0;
      endcase
   end

   // Relay sequencing
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= FAR_ST_STOP;
         on_cnt_reg <= 2'h0;
         pos_d_reg <= 1'b0;
      end else if (clk_en_i) begin
         pos_d_reg <= positioning_i;
         if (!meas_i.running || !enabled) begin
            state_reg <= FAR_ST_STOP;
         end else if (positioning_i && !pos_d_reg) begin
            state_reg <= FAR_ST_IDLE;
            on_cnt_reg <= 2'h0;
         end else if (rst_req) begin
            state_reg <= FAR_ST_HOLD;
            on_cnt_reg <= 2'h0;
         end else if (!adapting_i && !positioning_i) begin
            unique case (state_reg)
               FAR_ST_STOP: state_reg <= FAR_ST_IDLE;
               FAR_ST_IDLE: begin
                  if (cond) begin
                     state_reg <= FAR_ST_ACTIVE;
                     on_cnt_reg <= 2'h0;
                  end
               end
               FAR_ST_ACTIVE: begin
                  // Two ticks give at least 1 s of on-time
                  if (tick && on_cnt_reg < 2'h2) begin
                     on_cnt_reg <= on_cnt_reg + 2'h1;
                  end
                  if (!latch && !cond && on_cnt_reg == 2'h2) begin
                     state_reg <= FAR_ST_IDLE;
                  end
               end
               FAR_ST_HOLD: begin
                  // Wait 1 s before re-arming after manual reset
                  if (tick) begin
                     on_cnt_reg <= on_cnt_reg + 2'h1;
                  end
                  if (on_cnt_reg == 2'h2) begin
                     state_reg <= FAR_ST_IDLE;
                  end
               end
               default: state_reg <= FAR_ST_STOP;
            endcase
         end
      end
   end

   assign active = state_reg == FAR_ST_ACTIVE;

   // Contact drive; latched alarm held until reset, stop or positioning start
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         alarm_relay_output_o <= 1'b0;
      end else if (clk_en_i) begin
         // Inputs looked at too, so the contact drops on the same edge as the state
         if (state_reg == FAR_ST_STOP || !meas_i.running || !enabled) begin
            alarm_relay_output_o <= 1'b0;
         end else begin
            alarm_relay_output_o <= active ^ ctrl_reg[FAR_CTRL_NC];
         end
      end
   end

   // Never energized without measurement
   property p_stop_off;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (clk_en_i && !meas_i.running) |=> !alarm_relay_output_o;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("relay on while stopped");

   // Reset request idles relay next cycle
   property p_rst_idle;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (rst_req && meas_i.running && enabled && !positioning_i) |=> state_reg == FAR_ST_HOLD;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("reset did not idle");

   // Off function keeps NO polarity
   property p_off_no;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (func == FAR_FUNC_OFF) |-> !ctrl_reg[FAR_CTRL_NC];
   endproperty
   a_off_no: assert property (p_off_no) else $error("off with NC polarity");

   // Level only moves on a tick
   property p_pace;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      !tick |=> $stable(lvl_reg);
   endproperty
   a_pace: assert property (p_pace) else $error("level moved off tick");

   // Polarity mapping one cycle on
   property p_pol;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (clk_en_i && state_reg != FAR_ST_STOP && meas_i.running && enabled) |=>
         alarm_relay_output_o == ($past(active) ^ $past(ctrl_reg[FAR_CTRL_NC]));
   endproperty
   a_pol: assert property (p_pol) else $error("wrong contact polarity");

   // Ignored reset while totalizer reset is on
   property p_tot_block;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      ctrl_reg[FAR_CTRL_TOTRST] |-> !rst_req;
   endproperty
   a_tot_block: assert property (p_tot_block) else $error("reset not blocked");

   // Positioning start idles relay
   property p_pos;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (clk_en_i && positioning_i && !pos_d_reg && meas_i.running && enabled)
         |=> state_reg == FAR_ST_IDLE;
   endproperty
   a_pos: assert property (p_pos) else $error("positioning not idle");

   // Adaptation freezes the state
   property p_adapt;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (clk_en_i && adapting_i && meas_i.running && enabled && !rst_req && !positioning_i)
         |=> $stable(state_reg);
   endproperty
   a_adapt: assert property (p_adapt) else $error("switched during adaptation");

   // Latched alarm stays active until reset, stop or positioning
   property p_latch_hold;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (clk_en_i && active && latch && meas_i.running && enabled && !rst_req
         && !(positioning_i && !pos_d_reg)) |=> active;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

endmodule

`default_nettype wire

// >>> verif/far_contact_model.sv
// Model of the external alarm circuit wired to the relay contact
`timescale 1ns/1ns
`default_nettype none

module far_contact_model (
   input wire logic coil_i,
   output logic closed_o
);
   // Passive load: the contact closes only while the coil is energized
   assign closed_o = coil_i;
endmodule

`default_nettype wire

// >>> verif/test_far_relay.sv
// Self-checking bench for the alarm relay block
`timescale 1ns/1ns
`default_nettype none

module test_far_relay;
   import far_pkg::*;
   // Short tick keeps the run brief; step waits are counted in ticks
   localparam int TC = 10;
   localparam int NF = 5;
   typedef struct {int kind; logic [31:0] v;} far_note_s;
   logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, positioning_i, adapting_i;
   logic vcont, vpulse, closed, rd_q, obs_q, obs, disp, coil, clk_en;
   logic [3:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, seed, got;
   far_meas_s meas, meas_c;
   far_note_s notes[$];
   far_note_s note;
   int fail_count, n_tests;

   far_relay #(.TICK_CYC(TC), .ERR_FAILS(NF)) u_far_relay (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_i(meas_c),
      .positioning_i(positioning_i), .adapting_i(adapting_i),
      .alarm_relay_output_o(coil), .relay_state_display_enable_o(disp)
   );
   far_contact_model u_far_contact_model (.coil_i(coil), .closed_o(closed));

   // Clock
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   // Valid is either a steady stream or counted single pulses
   always_comb begin
      meas_c = meas;
      meas_c.valid = vpulse | vcont;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic tk(input int n);
      cyc(n * TC);
   endtask

   // Strobes drop for a cycle between calls, so no signal is set twice per step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      cyc(1);
      reg_wr_i <= 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      notes.push_back('{0, e});
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      cyc(1);
      reg_rd_i <= 1'b0;
      cyc(1);
   endtask

   task automatic chk(input int k, input logic [31:0] e);
      notes.push_back('{k, e});
      obs <= 1'b1;
      cyc(1);
      obs <= 1'b0;
      cyc(1);
   endtask

   task automatic step(input logic [31:0] v, input int t, input logic e);
      meas.value <= v;
      tk(t);
      chk(1, {31'h0, e});
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         vpulse <= 1'b1;
         cyc(1);
         vpulse <= 1'b0;
         cyc(1);
      end
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   // Watcher: read data stand one cycle after the strobe, so compare then
   always @(posedge sys_clk_i) begin
      if (rd_q || obs_q) begin
         note = notes.pop_front();
         got = (note.kind == 0) ? reg_rdata_o : (note.kind == 1) ? {31'h0, closed} :
            {31'h0, disp};
         check(got, note.v);
      end
      rd_q <= reg_rd_i;
      obs_q <= obs;
   end

   // Watchdog against a hang
   initial begin
      cyc(20000);
      fail_count++;
      end_sim();
   end

   initial begin
      seed = 32'h0000_CAE1;
      {nrst_i, reg_wr_i, reg_rd_i, positioning_i, adapting_i} = 5'h00;
      {vcont, vpulse, obs, clk_en} = 4'h1;
      reg_addr_i = 4'h0;
      reg_wdata_i = 32'h0;
      meas = '0;
      fail_count = 0;
      n_tests = 0;
      cyc(16);
      nrst_i <= 1'b1;
      cyc(1);
      rd(FAR_ADDR_CTRL, 32'h20);
      rd(FAR_ADDR_LIMIT, 32'h0);
      rd(FAR_ADDR_HYST, 32'h0);
      rd(4'h9, 32'h0);
      chk(1, 32'h0);
      wr(FAR_ADDR_CTRL, 32'h70);
      rd(FAR_ADDR_CTRL, 32'h60);
      chk(2, 32'h1);
      done("reset");
      meas.running <= 1'b1;
      vcont <= 1'b1;
      wr(FAR_ADDR_LIMIT, 32'h3E8);
      wr(FAR_ADDR_HYST, 32'hC8);
      wr(FAR_ADDR_CTRL, 32'h21);
      step(32'h41A + (xs() & 32'h1F), 4, 1'b0);
      step(32'h47E + (xs() & 32'h3F), 4, 1'b1);
      step(32'h3B6, 4, 1'b1);
      step(32'h352, 4, 1'b0);
      wr(FAR_ADDR_HYST, 32'h0);
      step(32'h3E9, 4, 1'b1);
      // Clock enable low freezes the level, so the contact holds
      clk_en <= 1'b0;
      step(32'h3E8, 4, 1'b1);
      clk_en <= 1'b1;
      step(32'h3E8, 4, 1'b0);
      wr(FAR_ADDR_LIMIT, 32'hFFFF_FE0C);
      wr(FAR_ADDR_CTRL, 32'h22);
      step(32'hFFFF_FE0B, 4, 1'b1);
      step(32'hFFFF_FE0D, 4, 1'b0);
      done("levels");
      wr(FAR_ADDR_CTRL, 32'h32);
      step(32'hFFFF_FE0D, 2, 1'b1);
      step(32'hFFFF_FE0B, 4, 1'b0);
      positioning_i <= 1'b1;
      step(32'hFFFF_FE0B, 1, 1'b1);
      positioning_i <= 1'b0;
      meas.running <= 1'b0;
      step(32'hFFFF_FE0D, 2, 1'b0);
      meas.running <= 1'b1;
      wr(FAR_ADDR_CTRL, 32'h12);
      step(32'hFFFF_FE0D, 1, 1'b0);
      rd(FAR_ADDR_CTRL, 32'h12);
      rd(FAR_ADDR_LIMIT, 32'hFFFF_FE0C);
      done("polarity");
      wr(FAR_ADDR_LIMIT, 32'h3E8);
      wr(FAR_ADDR_CTRL, 32'h29);
      step(32'h4B0, 4, 1'b1);
      step(32'h384, 4, 1'b1);
      wr(FAR_ADDR_CTRL, 32'hA9);
      wr(FAR_ADDR_CMD, 32'h1);
      step(32'h384, 1, 1'b1);
      wr(FAR_ADDR_CTRL, 32'h29);
      wr(FAR_ADDR_CMD, 32'h1);
      step(32'h384, 4, 1'b0);
      step(32'h4B0, 4, 1'b1);
      wr(FAR_ADDR_CMD, 32'h1);
      chk(1, 32'h0);
      step(32'h4B0, 4, 1'b1);
      positioning_i <= 1'b1;
      step(32'h384, 1, 1'b0);
      positioning_i <= 1'b0;
      step(32'h384, 4, 1'b0);
      wr(FAR_ADDR_CTRL, 32'h21);
      step(32'h384, 4, 1'b0);
      adapting_i <= 1'b1;
      step(32'h4B0, 4, 1'b0);
      adapting_i <= 1'b0;
      step(32'h4B0, 4, 1'b1);
      done("latch");
      wr(FAR_ADDR_CTRL, 32'h23);
      step(32'h64, 4, 1'b0);
      step(32'hFFFF_FF9C, 1, 1'b1);
      step(32'hFFFF_FF9C, 4, 1'b0);
      wr(FAR_ADDR_CTRL, 32'h2B);
      step(32'h64, 1, 1'b1);
      step(32'h64, 4, 1'b1);
      wr(FAR_ADDR_CMD, 32'h1);
      step(32'h64, 4, 1'b0);
      done("direction");
      wr(FAR_ADDR_LIMIT, 32'h1F4);
      wr(FAR_ADDR_CTRL, 32'h24);
      meas.total_pos <= 32'h1F3;
      step(32'h64, 4, 1'b0);
      meas.total_pos <= 32'h1F4;
      step(32'h64, 4, 1'b1);
      wr(FAR_ADDR_CTRL, 32'h25);
      vcont <= 1'b0;
      meas.fail <= 1'b1;
      pulses(NF - 1);
      step(32'h64, 3, 1'b0);
      meas.fail <= 1'b0;
      pulses(1);
      meas.fail <= 1'b1;
      pulses(NF - 1);
      step(32'h64, 3, 1'b0);
      pulses(1);
      step(32'h64, 3, 1'b1);
      // Status: dir armed, level low, relay, active, condition, running
      rd(FAR_ADDR_STAT, 32'h2F);
      done("quantity_error");
      end_sim();
   end
endmodule

`default_nettype wire
